// ### design/rgfac_cfg.svh
// Overview of operation
// - Six-bit receive gain, 60 dB span
// - Total gain -12 to 48 dB
// - Coarse stage -12 to 42 dB, 6 dB
// - Fine stage 0 to 6 dB, 1 dB
// - Selectable split table: noise or distortion
// - Gain from port, legacy, nibble, serial
// - Fast port updates gain without strobe
// - Port writes transmit gain only when enabled
// - Receive enable steers port in half duplex
// - Legacy codes: 0,1 -10 dB, +8 dB steps
// - Filter cutoff field, default 23 MHz
// - Filter bypass setting
// - Calibrate filter after power-up
// - Serial write restarts filter calibration
// - Converter power level selectable
// - Converter full power-down allowed
// - Ten-bit samples up to 80 MSPS
// - Default format: binary half, signed full
// - Serial bit overrides sample format
// - Legacy default updates only receive gain
// - Reset: transmit full scale, port disabled for transmit
`ifndef RGFAC_CFG_SVH
`define RGFAC_CFG_SVH
`define RGFAC_A_GAIN 4'h0
`define RGFAC_A_CTRL 4'h1
`define RGFAC_A_FILT 4'h2
`define RGFAC_A_ADC 4'h3
`define RGFAC_A_TXG 4'h4
`define RGFAC_A_STAT 4'h5
`define RGFAC_C_EXT 0
`define RGFAC_C_TXEN 1
`define RGFAC_C_LUT 2
`define RGFAC_C_FOVR 3
`define RGFAC_C_FSGN 4
`define RGFAC_F_BYP 4
`define RGFAC_F_CAL 5
`define RGFAC_A_PD 2
`define RGFAC_RXG_RST 6'h0C
`define RGFAC_TXG_RST 6'h00
`define RGFAC_CUT_RST 4'h3
`define RGFAC_PWR_RST 2'h3
`define RGFAC_CAL_NS 10240
`define RGFAC_CLK_MHZ 25
`define RGFAC_CAL_CYC (`RGFAC_CAL_NS * `RGFAC_CLK_MHZ / 1000)
`endif

// ### design/rgfac_pkg.sv
package rgfac_pkg;
    // Coarse and fine code pair driving the analog stages
    typedef struct packed {
        logic [3:0] coarse; // 6 dB steps, 0 means -12 dB
        logic [2:0] fine;   // 1 dB steps
    } rgfac_split_s;
    // Calibration sequencer states
    typedef enum logic [1:0] {
        RGFAC_CAL_IDLE = 2'b00,
        RGFAC_CAL_RUN = 2'b01,
        RGFAC_CAL_DONE = 2'b10
    } rgfac_cal_e;
endpackage

// ### design/rgfac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rgfac_cfg.svh"
module rgfac_top #(
    parameter int CAL_CYCLES = `RGFAC_CAL_CYC, // Calibration run length
    parameter int ADC_W = 10                   // Sample width
) (
    input wire logic clk,                       // 25 MHz clock
    input wire logic rst_n,                     // Async reset, active low
    input wire logic [3:0] reg_addr,            // Register address
    input wire logic [7:0] reg_wdata,           // Write data
    input wire logic reg_wr,                    // Write strobe
    input wire logic reg_rd,                    // Read strobe
    output logic [7:0] reg_rdata,               // Read data, next cycle
    input wire logic full_duplex,               // Interface mode strap
    input wire logic [5:0] fast_gain_port,      // Asynchronous gain pins
    input wire logic receive_enable_input,      // Half-duplex steering pin
    input wire logic nib_gain_sel,              // Nibble bus carries gain
    input wire logic nibble_phase_strobe,       // Nibble phase
    input wire logic [5:0] nib_data,            // Transmit nibble bus
    input wire logic [ADC_W-1:0] adc_raw,       // Raw offset-binary sample
    input wire logic adc_valid,                 // Sample valid
    output logic [ADC_W-1:0] adc_out,           // Formatted sample
    output logic adc_out_valid,                 // Formatted sample valid
    output rgfac_pkg::rgfac_split_s rx_split,   // Stage codes
    output logic [5:0] tx_level_amp,            // Transmit gain
    output logic [3:0] filt_cutoff,             // Filter cutoff code
    output logic filt_bypass,                   // Filter bypassed
    output logic filt_cal_busy,                 // Calibration running
    output logic [1:0] adc_power,               // Converter power level
    output logic adc_pd                         // Converter powered down
);
    // Register state
    logic [5:0] rx_gain_q;      // Receive gain, 0 = -12 dB
    logic [5:0] tx_gain_q;      // Transmit gain
    logic [4:0] ctrl_q;         // Control bits
    logic [4:0] filt_q;         // Cutoff and bypass
    logic [2:0] adc_q;          // Power level and power-down
    logic cal_req_q;            // Pending calibration request
    rgfac_pkg::rgfac_cal_e cal_st_q;
    logic [31:0] cal_cnt_q;     // Calibration counter
    logic [5:0] s1_q, s2_q, s3_q; // Three-stage pin synchroniser
    logic [5:0] fg_q;           // Accepted fast port value
    logic fg_new_q;             // One-cycle pulse on a new value
    logic [2:0] re1_q, re2_q, re3_q; // Pin syncs: receive_enable_input, gsel, phase
    logic re_q, gs_q, ph_q, ph_prev_q;
    logic [5:0] nib1_q, nib2_q, nib3_q, nib_q;
    logic wr_gain, port_to_tx, port_to_rx, nib_load;
    logic sgn_fmt;

    // Legacy three-bit code to six-bit gain, -10 dB plus 8 dB per step
    function automatic logic [5:0] legacy_gain(input logic [2:0] c);
        logic [5:0] g;
        g = 6'h00;
        if (c <= 3'h1) begin
            g = 6'h02; // -10 dB
        end else begin
            g = 6'(6'h02 + 6'({c - 3'h1, 3'h0}));
        end
        return g;
    endfunction

    // Split total gain into coarse and fine codes
    // Noise table loads the coarse stage first; distortion keeps it low
    function automatic rgfac_pkg::rgfac_split_s split(
        input logic [5:0] g, input logic distort);
        rgfac_pkg::rgfac_split_s s;
        logic [3:0] c;
        logic [5:0] r;
        s = '0;
        c = 4'(g / 6'd6);
        if (c > 4'h9) begin
            c = 4'h9; // Coarse stage tops out at 42 dB
        end
        // Widen before the product: a 4-bit product wraps at 16
        r = 6'(g - 6'(c) * 6'h06);
        if (distort && c != 4'h0 && r == 6'h00 && g != 6'd60) begin
            c = 4'(c - 4'h1); // Shift 6 dB to fine stage
            r = 6'h06;
        end
        s.coarse = c;
        s.fine = 3'(r);
        return s;
    endfunction

    // Fast port pins: three flops, change taken when second and third agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
            fg_q <= 6'h00;
            fg_new_q <= 1'b0;
        end else begin
            s1_q <= fast_gain_port;
            s2_q <= s1_q;
            s3_q <= s2_q;
            fg_new_q <= 1'b0;
            // Whole word taken at once, so no torn gain reaches the table
            if (s2_q == s3_q && s3_q != fg_q) begin
                fg_q <= s3_q;
                fg_new_q <= 1'b1;
            end
        end
    end

    // Control pins and nibble bus synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            re1_q <= 3'h0;
            re2_q <= 3'h0;
            re3_q <= 3'h0;
            nib1_q <= 6'h00;
            nib2_q <= 6'h00;
            nib3_q <= 6'h00;
            nib_q <= 6'h00;
            re_q <= 1'b0;
            gs_q <= 1'b0;
            ph_q <= 1'b0;
            ph_prev_q <= 1'b0;
        end else begin
            re1_q <= {nibble_phase_strobe, nib_gain_sel, receive_enable_input};
            re2_q <= re1_q;
            re3_q <= re2_q;
            nib1_q <= nib_data;
            nib2_q <= nib1_q;
            nib3_q <= nib2_q;
            if (nib2_q == nib3_q) begin
                nib_q <= nib3_q;
            end
            if (re2_q[0] == re3_q[0]) begin
                re_q <= re3_q[0];
            end
            if (re2_q[1] == re3_q[1]) begin
                gs_q <= re3_q[1];
            end
            if (re2_q[2] == re3_q[2]) begin
                ph_q <= re3_q[2];
            end
            ph_prev_q <= ph_q;
        end
    end

    // Steering of the fast port value
    always_comb begin
        wr_gain = reg_wr && reg_addr == `RGFAC_A_GAIN;
        // Transmit path only with enable bit, half duplex, receive_enable_input low
        port_to_tx = fg_new_q && ctrl_q[`RGFAC_C_TXEN]
            && ctrl_q[`RGFAC_C_EXT] && !full_duplex && !re_q;
        // Receive path otherwise; legacy default never touches transmit
        port_to_rx = fg_new_q && !port_to_tx;
        // Gain word on nibble bus, taken on the phase rising edge
        nib_load = gs_q && ph_q && !ph_prev_q;
    end

    // Receive gain register; the fast port wins a same-cycle clash
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_gain_q <= `RGFAC_RXG_RST;
        end else if (port_to_rx) begin
            if (ctrl_q[`RGFAC_C_EXT] || full_duplex) begin
                rx_gain_q <= (fg_q > 6'd60) ? 6'd60 : fg_q;
            end else begin
                rx_gain_q <= legacy_gain(fg_q[5:3]);
            end
        end else if (nib_load) begin
            rx_gain_q <= (nib_q > 6'd60) ? 6'd60 : nib_q;
        end else if (wr_gain) begin
            // Clamp to 60 dB span, 1 dB per code
            rx_gain_q <= (reg_wdata[5:0] > 6'd60) ? 6'd60 : reg_wdata[5:0];
        end
    end

    // Transmit gain register, full scale at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_gain_q <= `RGFAC_TXG_RST;
        end else if (port_to_tx) begin
            tx_gain_q <= fg_q;
        end else if (reg_wr && reg_addr == `RGFAC_A_TXG) begin
            tx_gain_q <= reg_wdata[5:0];
        end
    end

    // Control, filter and converter registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 5'h00; // Port disabled for transmit
            filt_q <= {1'b0, `RGFAC_CUT_RST};
            adc_q <= {1'b0, `RGFAC_PWR_RST};
        end else if (reg_wr) begin
            case (reg_addr)
                `RGFAC_A_CTRL: begin
                    ctrl_q <= reg_wdata[4:0];
                end
                `RGFAC_A_FILT: begin
                    filt_q <= reg_wdata[4:0];
                end
                `RGFAC_A_ADC: begin
                    adc_q <= reg_wdata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Calibration request: a new request during a run is held, not lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_req_q <= 1'b1; // Power-up calibration
        end else if (reg_wr && reg_addr == `RGFAC_A_FILT
                && reg_wdata[`RGFAC_F_CAL]) begin
            cal_req_q <= 1'b1;
        end else if (cal_st_q != rgfac_pkg::RGFAC_CAL_RUN) begin
            cal_req_q <= 1'b0;
        end
    end

    // Calibration sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_st_q <= rgfac_pkg::RGFAC_CAL_IDLE;
            cal_cnt_q <= 32'h0;
        end else begin
            case (cal_st_q)
                rgfac_pkg::RGFAC_CAL_IDLE, rgfac_pkg::RGFAC_CAL_DONE: begin
                    if (cal_req_q) begin
                        cal_st_q <= rgfac_pkg::RGFAC_CAL_RUN;
                        cal_cnt_q <= 32'h0;
                    end
                end
                rgfac_pkg::RGFAC_CAL_RUN: begin
                    if (cal_cnt_q == 32'(CAL_CYCLES - 1)) begin
                        cal_st_q <= rgfac_pkg::RGFAC_CAL_DONE;
                    end else begin
                        cal_cnt_q <= cal_cnt_q + 32'h1;
                    end
                end
                default: begin
                    cal_st_q <= rgfac_pkg::RGFAC_CAL_IDLE;
                end
            endcase
        end
    end

    // Output sample format: mode default unless software overrides
    always_comb begin
        if (ctrl_q[`RGFAC_C_FOVR]) begin
            sgn_fmt = ctrl_q[`RGFAC_C_FSGN];
        end else begin
            sgn_fmt = full_duplex;
        end
    end

    // Sample path, one register stage; MSB flip gives two's complement
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_out <= '0;
            adc_out_valid <= 1'b0;
        end else begin
            adc_out_valid <= adc_valid && !adc_q[`RGFAC_A_PD];
            if (adc_valid) begin
                adc_out <= adc_raw ^ {sgn_fmt, {(ADC_W-1){1'b0}}};
            end
        end
    end

    // Stage codes follow the gain register through the table
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_split <= '0;
        end else begin
            rx_split <= split(rx_gain_q, ctrl_q[`RGFAC_C_LUT]);
        end
    end

    // Read port, data the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `RGFAC_A_GAIN: reg_rdata <= {2'h0, rx_gain_q};
                `RGFAC_A_CTRL: reg_rdata <= {3'h0, ctrl_q};
                `RGFAC_A_FILT: reg_rdata <= {3'h0, filt_q};
                `RGFAC_A_ADC: reg_rdata <= {5'h0, adc_q};
                `RGFAC_A_TXG: reg_rdata <= {2'h0, tx_gain_q};
                `RGFAC_A_STAT: reg_rdata <= {6'h0, cal_st_q};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Analog controls straight from registers
    always_comb begin
        tx_level_amp = tx_gain_q;
        filt_cutoff = filt_q[3:0];
        filt_bypass = filt_q[`RGFAC_F_BYP];
        filt_cal_busy = cal_st_q == rgfac_pkg::RGFAC_CAL_RUN;
        adc_power = adc_q[1:0];
        adc_pd = adc_q[`RGFAC_A_PD];
    end
endmodule // rgfac_top
`default_nettype wire

// ### bench/rgfac_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rgfac_chk #(
    parameter int CAL_CYCLES = 4 // Run length
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic [3:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Data
    input wire logic reg_wr, // Write
    input wire logic full_duplex, // Mode
    input wire logic [5:0] fast_gain_port, // Pins
    input wire logic adc_valid, // In valid
    input wire logic adc_out_valid, // Out valid
    input wire rgfac_pkg::rgfac_split_s rx_split, // Stages
    input wire logic [5:0] tx_level_amp, // Tx gain
    input wire logic [3:0] filt_cutoff, // Cutoff
    input wire logic filt_bypass, // Bypass
    input wire logic filt_cal_busy, // Busy
    input wire logic [1:0] adc_power, // Power
    input wire logic adc_pd // Down
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] run_q; // Busy cycles so far
    logic f_w; // Filter write
    logic a_w; // Converter write
    assign f_w = reg_wr && reg_addr == 4'h2;
    assign a_w = reg_wr && reg_addr == 4'h3;
    // Count busy cycles so a short or long run shows
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 8'h00;
        end else begin
            run_q <= filt_cal_busy ? run_q + 8'h01 : 8'h00;
        end
    end
    property p_val; adc_valid && !adc_pd |=> adc_out_valid; endproperty
    a_val: assert property (p_val) else $error("sample lost");
    property p_pd; adc_pd |=> !adc_out_valid; endproperty
    a_pd: assert property (p_pd) else $error("sample while down");
    property p_len; $fell(filt_cal_busy) |-> run_q == CAL_CYCLES; endproperty
    a_len: assert property (p_len) else $error("cal length");
    property p_req; f_w && reg_wdata[5] |-> ##[1:3] filt_cal_busy; endproperty
    a_req: assert property (p_req) else $error("cal not run");
    property p_byp; f_w |=> filt_bypass == $past(reg_wdata[4]); endproperty
    a_byp: assert property (p_byp) else $error("bypass");
    property p_cut; f_w |=> filt_cutoff == $past(reg_wdata[3:0]); endproperty
    a_cut: assert property (p_cut) else $error("cutoff");
    property p_pwr;
        a_w |=> {adc_pd, adc_power} == $past(reg_wdata[2:0]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power");
    // Full duplex never steers the port to transmit gain
    property p_txfd;
        full_duplex [*6] ##1 (full_duplex && $changed(tx_level_amp))
            |-> $past(reg_wr && reg_addr == 4'h4);
    endproperty
    a_txfd: assert property (p_txfd) else $error("tx moved");
    property p_fast;
        $changed(fast_gain_port) ##1
            (full_duplex && !reg_wr && $stable(fast_gain_port)) [*7]
            |-> rx_split.coarse * 7'h06 + rx_split.fine ==
                (fast_gain_port > 6'h3C ? 7'h3C : {1'b0, fast_gain_port});
    endproperty
    a_fast: assert property (p_fast) else $error("fast gain");
    c_cal: cover property ($fell(filt_cal_busy));
    c_pd: cover property (adc_pd && adc_valid);
    c_tx: cover property ($changed(tx_level_amp) && !full_duplex);
endmodule // rgfac_chk
bind rgfac_top rgfac_chk #(.CAL_CYCLES(CAL_CYCLES)) rgfac_chk_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .full_duplex(full_duplex),
    .fast_gain_port(fast_gain_port), .adc_valid(adc_valid),
    .adc_out_valid(adc_out_valid), .rx_split(rx_split),
    .tx_level_amp(tx_level_amp), .filt_cutoff(filt_cutoff),
    .filt_bypass(filt_bypass), .filt_cal_busy(filt_cal_busy),
    .adc_power(adc_power), .adc_pd(adc_pd));
`default_nettype wire

// ### bench/rgfac_bb.sv
`timescale 1ns/1ps
`default_nettype none
module rgfac_bb (
    input wire logic clk, // Clock
    output logic [5:0] fast_gain_port, // Gain pins
    output logic receive_enable_input, // Steering
    output logic nib_gain_sel, // Nibble gain
    output logic nibble_phase_strobe, // Phase
    output logic [5:0] nib_data // Nibble bus
);
    // Idle pins; port matches the synchroniser reset word, so no update
    initial begin
        fast_gain_port = 6'h00;
        receive_enable_input = 1'b1;
        nib_gain_sel = 1'b0;
        nibble_phase_strobe = 1'b0;
        nib_data = 6'h2A;
    end
    // Whole word at once, so no half-changed gain is seen
    task automatic fast(input logic [5:0] v, input logic rx);
        @(posedge clk);
        fast_gain_port <= v;
        receive_enable_input <= rx;
    endtask
    // Nibble gain load; slow stretches each phase
    task automatic nib(input logic [5:0] v, input int slow);
        @(posedge clk);
        nib_gain_sel <= 1'b1;
        nib_data <= v;
        repeat (slow + 1) @(posedge clk);
        nibble_phase_strobe <= 1'b1;
        repeat (slow + 3) @(posedge clk);
        nibble_phase_strobe <= 1'b0;
        nib_gain_sel <= 1'b0;
        nib_data <= ~v; // Released bus keeps no stale word
    endtask
endmodule // rgfac_bb
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_n, reg_wr, reg_rd, full_duplex, rxe, gs, ph, adc_valid;
    logic [3:0] reg_addr, filt_cutoff;
    logic [7:0] reg_wdata, reg_rdata;
    logic [5:0] fgp, nd, tx, v, p, t_e, g_e;
    logic [9:0] adc_raw, adc_out;
    logic adc_out_valid, filt_bypass, busy, adc_pd, lut, txen, rx, sg;
    logic [1:0] adc_power;
    rgfac_pkg::rgfac_split_s rx_split;
    int n_errors, n_tests, cyc;
    rgfac_top #(.CAL_CYCLES(4)) rgfac_top_i (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .full_duplex(full_duplex),
        .fast_gain_port(fgp), .receive_enable_input(rxe),
        .nib_gain_sel(gs), .nibble_phase_strobe(ph), .nib_data(nd),
        .adc_raw(adc_raw), .adc_valid(adc_valid), .adc_out(adc_out),
        .adc_out_valid(adc_out_valid), .rx_split(rx_split),
        .tx_level_amp(tx), .filt_cutoff(filt_cutoff),
        .filt_bypass(filt_bypass), .filt_cal_busy(busy),
        .adc_power(adc_power), .adc_pd(adc_pd));
    rgfac_bb rgfac_bb_i (.clk(clk), .fast_gain_port(fgp),
        .receive_enable_input(rxe), .nib_gain_sel(gs),
        .nibble_phase_strobe(ph), .nib_data(nd));
    // Expected stage split; distortion table moves 6 dB to fine
    function automatic logic [7:0] split(logic [5:0] g, logic l);
        logic [3:0] c;
        c = (g >= 6'h36) ? 4'h9 : 4'(g / 6'h06);
        if (l && g != 6'h00 && g % 6'h06 == 6'h00 && g < 6'h3C) c = c - 4'h1;
        return {1'b0, c, 3'(g - 6'h06 * c)};
    endfunction
    function automatic logic [5:0] clamp(logic [5:0] g);
        return (g > 6'h3C) ? 6'h3C : g;
    endfunction
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // Writes leave a gap cycle so a strobe never changes twice at once
    task automatic wr(logic [3:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, e);
        @(posedge clk);
    endtask
    // One sample through the output formatter
    task automatic samp(logic s, logic on);
        adc_raw <= 10'($urandom);
        adc_valid <= 1'b1;
        @(posedge clk);
        adc_valid <= 1'b0;
        #1 chk("adc_out_valid", adc_out_valid, on);
        if (on) chk("adc_out", adc_out, {adc_raw[9] ^ s, adc_raw[8:0]});
        @(posedge clk);
    endtask
    task automatic results;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard, far above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        {rst_n, reg_wr, reg_rd, full_duplex, adc_valid} = 5'h00;
        {reg_addr, reg_wdata, adc_raw, cyc} = '0;
        void'($urandom(32'h1271));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("busy", busy, 1'b1);
        repeat (8) @(posedge clk);
        rd(4'h0, 8'h0C);
        rd(4'h2, 8'h03);
        rd(4'h3, 8'h03);
        rd(4'h4, 8'h00);
        rd(4'h5, 8'h02);
        rd(4'hF, 8'h00);
        // Legacy three-bit codes, both steering levels
        for (int c = 0; c < 8; c++) begin
            rgfac_bb_i.fast({3'(c), 3'($urandom) | 3'h1}, c[0]);
            repeat (7) @(posedge clk);
            #1 chk("split", rx_split, split(c < 2 ? 6'h02 : 6'(2 + 8 * (c - 1)), 0));
        end
        chk("tx", tx, 6'h00);
        // Extended port: both tables, tx path on and off
        {g_e, t_e, p} = {6'h2A, 6'h00, fgp};
        for (int i = 0; i < 12; i++) begin
            v = (i < 2) ? {6{i[0]}} : 6'($urandom);
            if (v == p) v = ~v;
            {lut, txen, rx} = {i[0], i[1], i[2]};
            wr(4'h1, {5'h00, lut, txen, 1'b1});
            rgfac_bb_i.fast(v, rx);
            repeat (7) @(posedge clk);
            if (txen && !rx) t_e = v;
            else g_e = clamp(v);
            p = v;
            #1 chk("split", rx_split, split(g_e, lut));
            chk("tx", tx, t_e);
        end
        // Full duplex: port, serial write, nibble bus
        full_duplex <= 1'b1;
        rgfac_bb_i.fast(6'h3D, 1'b0);
        repeat (7) @(posedge clk);
        #1 chk("split", rx_split, split(6'h3C, 1));
        chk("tx", tx, t_e);
        wr(4'h0, 8'h05);
        rd(4'h0, 8'h05);
        rgfac_bb_i.nib(6'h3E, 0);
        repeat (5) @(posedge clk);
        rd(4'h0, 8'h3C);
        rgfac_bb_i.nib(6'h07, 2);
        repeat (5) @(posedge clk);
        rd(4'h0, 8'h07);
        wr(4'h4, 8'h21);
        rd(4'h4, 8'h21);
        // Sample format, every mode and override
        for (int k = 0; k < 8; k++) begin
            full_duplex <= k[0];
            wr(4'h1, {3'h0, k[2], k[1], 3'h0});
            sg = k[1] ? k[2] : k[0];
            samp(sg, 1'b1);
        end
        // Power levels and power-down
        for (int q = 0; q < 8; q++) begin
            wr(4'h3, 8'(q));
            chk("power", {adc_pd, adc_power}, 8'(q));
            samp(sg, !q[2]);
        end
        // Cutoff and bypass, then a calibration request
        for (int i = 0; i < 4; i++) begin
            v = 6'($urandom);
            wr(4'h2, {3'h0, i[0], v[3:0]});
            chk("filter", {filt_bypass, filt_cutoff}, {i[0], v[3:0]});
        end
        wr(4'h2, 8'h23);
        #1 chk("busy", busy, 1'b1);
        repeat (8) @(posedge clk);
        rd(4'h5, 8'h02);
        rd(4'h2, 8'h03);
        results();
    end
endmodule // tb
`default_nettype wire
